/* rtl/tdm_stream_port.sv */
// TDM stream port: frame timing, 32 in and 32 out serial streams.
// Assumes pins are asynchronous; bit clock well below clk_i / 4.
// Function
// - Frame pulse active low, high if selected
// - Format bit selects GCI framing
// - Bit clock 4.096, 8.192 or 16.384 MHz
// - Boundary on falling edge, rising if selected
// - Inputs carry 32/64/128 channels per rate
// - Outputs carry 32/64/128 channels per rate
// - Per-stream independent input/output rates
// - Bits 7,6 of mode make outputs bidirectional
// - Buffer control only for streams 0-15
// - Drive enable low: tristate, controls high
`timescale 1ns/1ps
module tdm_stream_port (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        frame_pulse_input_i,
  input  wire logic        bit_clock_input_i,
  input  wire logic        output_drive_enable_i,
  input  wire logic [31:0] serial_input_streams_i,
  input  wire logic [31:0] serial_output_streams_i,
  output logic      [31:0] serial_output_streams_o,
  output logic      [31:0] serial_output_oe_n_o,
  output logic      [15:0] ext_buffer_hiz_control_o
);
  import tdm_port_pkg::*;
  // ==========================================================
  // Pin synchronisers
  logic [2:0]  pin_s;                  // Frame, clock, drive enable
  logic [31:0] si_s;                   // Input stream pins
  logic [31:0] sio_s;                  // Output pins read back

  sync2 #(.W(3)) u_sync_ctl (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({frame_pulse_input_i, bit_clock_input_i,
              output_drive_enable_i}),
    .q_o    (pin_s)
  );
  sync2 #(.W(64)) u_sync_dat (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({serial_input_streams_i, serial_output_streams_i}),
    .q_o    ({si_s, sio_s})
  );

  // ==========================================================
  // Registers
  logic [31:0]  main_control_register_q;   // Framing and clock mode
  logic [31:0]  internal_mode_select_q;    // Bidirectional selects
  logic [63:0]  stream_input_rate_ctrl_q;  // 2 bits per stream
  logic [63:0]  stream_output_rate_ctrl_q; // 2 bits per stream
  logic [15:0]  hiz_hi_q;                  // Hi-z, streams 16-31
  logic [255:0] chz_q [NUM_HIZ];           // Channel hi-z, 0-15
  logic [CNT_BITS-1:0] cnt_q;              // Bit clocks since boundary
  logic         req;                       // New bus request
  logic         hit_chz;                   // Address in hi-z table
  logic [31:0]  wmask;                     // Byte lane mask

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit_chz = (wb_adr_i & CHZ_MASK) == OFS_CHZ;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // Register writes, byte lanes honoured
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      main_control_register_q   <= CTRL_RST;
      internal_mode_select_q    <= CTRL_RST;
      stream_input_rate_ctrl_q  <= {RATE_RST, RATE_RST};
      stream_output_rate_ctrl_q <= {RATE_RST, RATE_RST};
      hiz_hi_q                  <= '0;
    end
    else if (req && wb_we_i)
    begin
      unique case (wb_adr_i)
        OFS_CTRL: main_control_register_q <=
          (main_control_register_q & ~wmask) | (wb_dat_i & wmask);
        OFS_MODE: internal_mode_select_q <=
          (internal_mode_select_q & ~wmask) | (wb_dat_i & wmask);
        OFS_ICR0: stream_input_rate_ctrl_q[31:0] <=
          (stream_input_rate_ctrl_q[31:0] & ~wmask) | (wb_dat_i & wmask);
        OFS_ICR1: stream_input_rate_ctrl_q[63:32] <=
          (stream_input_rate_ctrl_q[63:32] & ~wmask) | (wb_dat_i & wmask);
        OFS_OCR0: stream_output_rate_ctrl_q[31:0] <=
          (stream_output_rate_ctrl_q[31:0] & ~wmask) | (wb_dat_i & wmask);
        OFS_OCR1: stream_output_rate_ctrl_q[63:32] <=
          (stream_output_rate_ctrl_q[63:32] & ~wmask) | (wb_dat_i & wmask);
        OFS_HIZHI: hiz_hi_q <= (hiz_hi_q & ~wmask[15:0]) |
                               (wb_dat_i[15:0] & wmask[15:0]);
        default: ;                      // Table, status or unmapped
      endcase
    end
  end

  // Channel hi-z table, 8 words per stream
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < NUM_HIZ; i++)
        chz_q[i] <= '0;
    end
    else if (req && wb_we_i && hit_chz)
    begin
      for (int b = 0; b < 32; b++)
        if (wmask[b])
          chz_q[wb_adr_i[8:5]][{wb_adr_i[4:2], 5'(b)}] <= wb_dat_i[b];
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      wb_dat_o <= '0;
    else if (req)
    begin
      if (hit_chz)
        wb_dat_o <= chz_q[wb_adr_i[8:5]][{wb_adr_i[4:2], 5'h00} +: 32];
      else
        unique case (wb_adr_i)
          OFS_CTRL:  wb_dat_o <= main_control_register_q;
          OFS_MODE:  wb_dat_o <= internal_mode_select_q;
          OFS_STAT:  wb_dat_o <= {21'h000000, cnt_q};
          OFS_ICR0:  wb_dat_o <= stream_input_rate_ctrl_q[31:0];
          OFS_ICR1:  wb_dat_o <= stream_input_rate_ctrl_q[63:32];
          OFS_OCR0:  wb_dat_o <= stream_output_rate_ctrl_q[31:0];
          OFS_OCR1:  wb_dat_o <= stream_output_rate_ctrl_q[63:32];
          OFS_HIZHI: wb_dat_o <= {16'h0000, hiz_hi_q};
          default:   wb_dat_o <= '0;
        endcase
    end
  end

  // ==========================================================
  // Frame timing
  logic       frame_polarity_sel;      // 1: active high pulse
  logic       frame_gci_format_sel;    // 1: GCI framing
  logic       frame_boundary_edge_sel; // 1: rising edge boundary
  logic       master_clock_loopback_sel;
  logic [1:0] ck_rate;                 // Bit clock rate code
  logic       ck_d_q;                  // Previous clock sample
  logic [3:0] loop_q;                  // Internal tick divider
  logic       tick_q;                  // One pulse per bit clock
  logic       fp_act_q;                // Frame pulse seen at tick
  logic       fp_act;
  logic       edge_hit;
  logic [CNT_BITS-1:0] frame_last;

  assign frame_polarity_sel        = main_control_register_q[CTRL_POL];
  assign frame_gci_format_sel      = main_control_register_q[CTRL_GCI];
  assign frame_boundary_edge_sel   = main_control_register_q[CTRL_EDGE];
  assign master_clock_loopback_sel = main_control_register_q[CTRL_LOOP];
  assign ck_rate    = main_control_register_q[CTRL_CKR +: 2];
  // Frame lasts 512, 1024 or 2048 bit clocks
  assign frame_last = CNT_BITS'((11'h200 << ck_rate) - 11'h001);
  assign fp_act     = pin_s[2] == frame_polarity_sel;
  assign edge_hit   = frame_boundary_edge_sel ? (pin_s[1] && !ck_d_q)
                                              : (!pin_s[1] && ck_d_q);

  // Bit clock edge detect; loopback uses an internal divider
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      ck_d_q   <= 1'b0;
      loop_q   <= '0;
      tick_q   <= 1'b0;
      fp_act_q <= 1'b0;
    end
    else
    begin
      ck_d_q <= pin_s[1];
      loop_q <= (loop_q == LOOP_DIV) ? 4'h0 : loop_q + 4'h1;
      // Pins are tied in loopback, so they are ignored there
      tick_q <= master_clock_loopback_sel ? (loop_q == LOOP_DIV)
                                          : edge_hit;
      fp_act_q <= edge_hit && fp_act && !master_clock_loopback_sel;
    end
  end

  // Bit clock counter; pulse resets it at the boundary
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      cnt_q <= '0;
    else if (tick_q)
    begin
      if (fp_act_q)
        // GCI pulse sits after the boundary, one clock late
        cnt_q <= frame_gci_format_sel ? 11'h001 : 11'h000;
      else if (cnt_q >= frame_last)
        cnt_q <= '0;                  // Free run between pulses
      else
        cnt_q <= cnt_q + 11'h001;
    end
  end

  // ==========================================================
  // Per-stream serial engines
  logic ode_q;                         // Registered drive enable
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ode_q <= 1'b0;
    else
      ode_q <= pin_s[0];
  end

  for (genvar s = 0; s < NUM_STREAMS; s++)
  begin : g_stream
    logic [1:0] ir, orr;               // Input and output rate codes
    logic [2:0] ish, osh;              // Clocks per bit, as shift
    logic [7:0] och;                   // Output channel number
    logic [7:0] in_sh_q, cap_q, out_sh_q;
    logic       bidir, src, hz, ostart, imid, ilast;
    logic [CNT_BITS-1:0] imask, omask;

    assign ir  = stream_input_rate_ctrl_q[2*s +: 2];
    assign orr = stream_output_rate_ctrl_q[2*s +: 2];
    // Two clocks per bit at the fastest rate; clamp illegal codes
    assign ish = (ir > ck_rate) ? 3'h1 : 3'(ck_rate - ir) + 3'h1;
    assign osh = (orr > ck_rate) ? 3'h1 : 3'(ck_rate - orr) + 3'h1;
    assign imask = CNT_BITS'((11'h001 << ish) - 11'h001);
    assign omask = CNT_BITS'((11'h001 << osh) - 11'h001);
    assign och = 8'(cnt_q >> (osh + 3'h3));
    assign imid = (cnt_q & imask) == (imask >> 1);
    assign ilast = imid && (3'(cnt_q >> ish) == 3'h7);
    assign ostart = (cnt_q & omask) == '0;
    assign bidir = (s < 16) ? internal_mode_select_q[MODE_BIDIR_LO]
                            : internal_mode_select_q[MODE_BIDIR_HI];
    assign src = bidir ? sio_s[s] : si_s[s];
    if (s < NUM_HIZ)
    begin : g_hz
      assign hz = chz_q[s][och];
    end
    else
    begin : g_nohz
      assign hz = hiz_hi_q[s - NUM_HIZ];
    end

    // Input sampled mid-bit, MSB first, byte kept per channel
    always_ff @(posedge clk_i)
    begin
      if (!rstn_i)
      begin
        in_sh_q <= '0;
        cap_q   <= '0;
      end
      else if (tick_q && imid)
      begin
        in_sh_q <= {in_sh_q[6:0], src};
        if (ilast)
          cap_q <= {in_sh_q[6:0], src};
      end
    end

    // Output loads the last captured byte at channel start
    always_ff @(posedge clk_i)
    begin
      if (!rstn_i)
      begin
        out_sh_q                   <= '0;
        serial_output_streams_o[s] <= 1'b0;
        serial_output_oe_n_o[s]    <= 1'b1;
      end
      else
      begin
        if (tick_q && ostart)
        begin
          out_sh_q <= (3'(cnt_q >> osh) == 3'h0) ? {cap_q[6:0], 1'b0}
                                                 : {out_sh_q[6:0], 1'b0};
          serial_output_streams_o[s] <= (3'(cnt_q >> osh) == 3'h0)
                                        ? cap_q[7] : out_sh_q[7];
        end
        serial_output_oe_n_o[s] <= hz || !ode_q;
      end
    end

    if (s < NUM_HIZ)
    begin : g_ctl
      // Buffer control tracks the pin drive state exactly
      always_ff @(posedge clk_i)
      begin
        if (!rstn_i)
          ext_buffer_hiz_control_o[s] <= 1'b1;
        else
          ext_buffer_hiz_control_o[s] <= hz || !ode_q;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_ode_tri;
    @(posedge clk_i) disable iff (!rstn_i)
    !ode_q |=> (&serial_output_oe_n_o) && (&ext_buffer_hiz_control_o);
  endproperty
  a_ode_tri: assert property (p_ode_tri)
    else $error("drive enable low but outputs active");

  property p_hz_pair;
    @(posedge clk_i) disable iff (!rstn_i)
    g_stream[0].hz |=> ext_buffer_hiz_control_o[0] && serial_output_oe_n_o[0];
  endproperty
  a_hz_pair: assert property (p_hz_pair)
    else $error("hi-z channel shows buffer control low");

  property p_hz_chan;
    @(posedge clk_i) disable iff (!rstn_i)
    (ode_q && !g_stream[0].hz) |=> !ext_buffer_hiz_control_o[0];
  endproperty
  a_hz_chan: assert property (p_hz_chan)
    else $error("driven channel shows buffer control high");

  property p_boundary;
    @(posedge clk_i) disable iff (!rstn_i)
    (tick_q && fp_act_q && !frame_gci_format_sel) |=> cnt_q == '0;
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("counter not cleared at frame boundary");

  property p_gci;
    @(posedge clk_i) disable iff (!rstn_i)
    (tick_q && fp_act_q && frame_gci_format_sel) |=> cnt_q == 11'h001;
  endproperty
  a_gci: assert property (p_gci)
    else $error("GCI boundary not one clock before pulse");

  property p_edge;
    @(posedge clk_i) disable iff (!rstn_i)
    (tick_q && !$past(master_clock_loopback_sel))
      |-> ($past(pin_s[1], 2) != $past(frame_boundary_edge_sel));
  endproperty
  a_edge: assert property (p_edge)
    else $error("tick taken on the wrong bit clock edge");

  property p_pol;
    @(posedge clk_i) disable iff (!rstn_i)
    fp_act_q |-> ($past(pin_s[2]) == $past(frame_polarity_sel));
  endproperty
  a_pol: assert property (p_pol)
    else $error("frame pulse taken at wrong polarity");

  property p_wrap;
    @(posedge clk_i) disable iff (!rstn_i)
    (tick_q && !fp_act_q && cnt_q >= frame_last) |=> cnt_q == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("frame counter overran frame length");

  property p_bidir;
    @(posedge clk_i) disable iff (!rstn_i)
    (tick_q && g_stream[16].imid && internal_mode_select_q[MODE_BIDIR_HI])
      |=> g_stream[16].in_sh_q[0] == $past(sio_s[16]);
  endproperty
  a_bidir: assert property (p_bidir)
    else $error("bidirectional stream not reading its pin");
endmodule : tdm_stream_port

/* rtl/tdm_port_pkg.sv */
// Shared constants for the TDM stream port timing block.
// Assumes a 125 MHz system clock and 32-bit classic Wishbone.
package tdm_port_pkg;
  // ==========================================================
  // Stream geometry
  localparam int NUM_STREAMS = 32;     // Input and output streams
  localparam int NUM_HIZ     = 16;     // Streams with buffer control
  localparam int CHAN_BITS   = 8;      // Up to 128 channels a frame
  localparam int CNT_BITS    = 11;     // Bit clocks in one frame
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000; // Main control
  localparam logic [11:0] OFS_MODE   = 12'h004; // Internal mode select
  localparam logic [11:0] OFS_STAT   = 12'h008; // Frame position
  localparam logic [11:0] OFS_ICR0   = 12'h010; // Input rates 0-15
  localparam logic [11:0] OFS_ICR1   = 12'h014; // Input rates 16-31
  localparam logic [11:0] OFS_OCR0   = 12'h018; // Output rates 0-15
  localparam logic [11:0] OFS_OCR1   = 12'h01c; // Output rates 16-31
  localparam logic [11:0] OFS_HIZHI  = 12'h020; // Hi-z, streams 16-31
  localparam logic [11:0] OFS_CHZ    = 12'h200; // Channel hi-z table
  localparam logic [11:0] CHZ_MASK   = 12'he00; // Table window decode
  // ==========================================================
  // Field positions
  localparam int CTRL_POL    = 0;      // Frame polarity select
  localparam int CTRL_GCI    = 1;      // GCI frame format select
  localparam int CTRL_EDGE   = 2;      // Boundary edge select
  localparam int CTRL_LOOP   = 3;      // Master clock loopback
  localparam int CTRL_CKR    = 4;      // Bit clock rate, 2 bits
  localparam int MODE_BIDIR_LO = 6;    // Bidir lower select
  localparam int MODE_BIDIR_HI = 7;    // Bidir upper select
  // ==========================================================
  // Reset values and timing
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RATE_RST = 32'h0000_0000; // 2.048 Mbps
  localparam logic [3:0]  LOOP_DIV = 4'h3; // Internal tick period - 1
  // Bit clock rate codes
  typedef enum logic [1:0] {
    CK_4M = 2'h0,
    CK_8M = 2'h1,
    CK_16M = 2'h2
  } ck_rate_t;
endpackage : tdm_port_pkg

/* rtl/sync2.sv */
// Two-flop synchroniser, parameterised width.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // ==========================================================
  // Metastability filter
  logic [W-1:0] meta_q;               // First stage, read only below

  // Second stage reads only the first stage
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : sync2

/* tb/tdm_source.sv */
// Far-end model: backplane timing source and TDM input devices.
// Assumes the port samples the bit clock with a much faster clock.
`timescale 1ns/1ps
module tdm_source (
  input  wire logic        pol_i,         // 1 = pulse active high
  input  wire logic        edge_i,        // 1 = boundary on rising edge
  input  wire logic [31:0] data_i,        // Constant bit per stream
  output logic             bit_clock_o,   // Free-running bit clock
  output logic             frame_pulse_o, // Frame pulse pin
  output logic             frame_o,       // High during bit 0
  output logic [31:0]      streams_o      // Serial input streams
);
  // ==========================================================
  // Pulse level and stream data
  logic on;  // Pulse asserted
  int   n;   // Bit clock index in the frame
  assign frame_pulse_o = on ? pol_i : ~pol_i;
  // Constant data per stream, so alignment cannot hide a swap
  assign streams_o     = data_i;
  // ==========================================================
  // 160 ns bit clock, 512 per frame; pulse 122 ns wide so that
  // it spans exactly one edge of the chosen kind
  // Frame length follows the bit clock rate code, not the stream rates; no stream
  // runs at 16.384 Mbps and loopback is never selected, so a free
  // clock and a 122 ns pulse are legal here
  initial
  begin
    on          = 1'b0;
    bit_clock_o = 1'b1;
    frame_o     = 1'b0;
    #3.3;
    forever
    begin
      for (n = 0; n < 512; n++)
      begin
        bit_clock_o = 1'b0;
        frame_o     = (n == 0);
        #19;
        if (edge_i && n == 0)
          on = 1'b1;
        #42;
        if (!edge_i)
          on = 1'b0;
        #19;
        bit_clock_o = 1'b1;
        #19;
        if (!edge_i && n == 511)
          on = 1'b1;
        #42;
        if (edge_i)
          on = 1'b0;
        #19;
      end
    end
  end
endmodule : tdm_source

/* tb/tdm_stream_port_timing_bench.sv */
// Self-checking bench: Wishbone register access and link timing.
// Assumes the far-end model in tdm_source and a 125 MHz clock.
`timescale 1ns/1ps
module tdm_stream_port_timing_bench;
  import tdm_port_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [31:0] PATTERN = 32'ha5c3_0f96; // Stream data
  logic        clk_i;                  // System clock
  logic        rstn_i;                 // Reset, active low
  logic        wb_cyc_i;               // Bus cycle
  logic        wb_stb_i;               // Bus strobe
  logic        wb_we_i;                // Write
  logic [11:0] wb_adr_i;               // Byte address
  logic [3:0]  wb_sel_i;               // Byte lanes
  logic [31:0] wb_dat_i;               // Write data
  logic [31:0] wb_dat_o;               // Read data
  logic        wb_ack_o;               // Acknowledge
  logic        fp_w;                   // Frame pulse pin
  logic        ck_w;                   // Bit clock pin
  logic        frame_w;                // Far-end frame marker
  logic        output_drive_enable;                    // Output drive enable
  logic [31:0] sin_w;                  // Input stream pins
  logic [31:0] out_w;                  // Output stream data
  logic [31:0] oe_n;                   // Output enables, low = drive
  logic [31:0] pin_w;                  // Resolved output pins
  logic [15:0] hiz;                    // Buffer control outputs
  logic        src_pol;                // Far-end pulse polarity
  logic        src_edge;               // Far-end boundary edge
  logic [31:0] src_dat;                // Far-end stream data
  logic [31:0] rdat;                   // Last read data
  int          err_count;              // Mismatches
  int          tests_run;              // Comparisons
  int          i;                      // Loop index
  int          k;                      // Cycle index
  int          hz_cnt;                 // Cycles with hiz[0] high
  int          hz_first;               // First such cycle
  int          hz_other;               // Cycles with others high
  int          oe_bad;                 // Enable disagreements
  logic [11:0] reg_ofs [8] = '{OFS_CTRL, OFS_MODE, OFS_ICR0, OFS_ICR1,
                               OFS_OCR0, OFS_OCR1, OFS_HIZHI, OFS_CHZ};
  // Frame position table: edge, polarity, GCI, plain last
  logic [31:0] pc_ctrl [4] = '{32'h4, 32'h1, 32'h2, 32'h0};
  logic [31:0] pc_exp  [4] = '{32'h27, 32'h28, 32'h29, 32'h28};
  logic [3:0]  pc_pol      = 4'b0010;
  logic [3:0]  pc_edge     = 4'b0001;
  // Released pins fall to the internal pull-down level
  assign pin_w = ~oe_n & out_w;
  // ==========================================================
  // Design and far end
  tdm_stream_port i_dut (
    .clk_i                    (clk_i),
    .rstn_i                   (rstn_i),
    .wb_cyc_i                 (wb_cyc_i),
    .wb_stb_i                 (wb_stb_i),
    .wb_we_i                  (wb_we_i),
    .wb_adr_i                 (wb_adr_i),
    .wb_sel_i                 (wb_sel_i),
    .wb_dat_i                 (wb_dat_i),
    .wb_dat_o                 (wb_dat_o),
    .wb_ack_o                 (wb_ack_o),
    .frame_pulse_input_i      (fp_w),
    .bit_clock_input_i        (ck_w),
    .output_drive_enable_i    (output_drive_enable),
    .serial_input_streams_i   (sin_w),
    .serial_output_streams_i  (pin_w),
    .serial_output_streams_o  (out_w),
    .serial_output_oe_n_o     (oe_n),
    .ext_buffer_hiz_control_o (hiz)
  );
  tdm_source i_src (
    .pol_i         (src_pol),
    .edge_i        (src_edge),
    .data_i        (src_dat),
    .bit_clock_o   (ck_w),
    .frame_pulse_o (fp_w),
    .frame_o       (frame_w),
    .streams_o     (sin_w)
  );
  // ==========================================================
  // Tasks
  // Verdict, counts and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // One comparison
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk
  // Classic cycle; held until ack, released for one cycle after
  task automatic wb_xfer(input logic we, input logic [11:0] adr,
                         input logic [31:0] dat, input logic [3:0] sel);
    int t;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    for (t = 0; t < 50; t++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (t == 50)
    begin
      $display("mismatch wb_ack expected 1 seen 0");
      err_count++;
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  // Read and compare
  task automatic rd_chk(input string what, input logic [11:0] adr,
                        input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0, 4'hf);
    chk(what, exp, rdat);
  endtask : rd_chk
  // Align to the next far-end frame start
  task automatic wait_frame();
    @(posedge frame_w);
    @(posedge clk_i);
  endtask : wait_frame
  // ==========================================================
  // Clock and watchdog; the run needs about 520 us
  initial
  begin
    clk_i = 1'b0;
    forever
      #4 clk_i = ~clk_i;
  end
  initial
  begin
    #720_000;
    err_count++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = '0;
    wb_dat_i = 32'h0;
    rstn_i   = 1'b0;
    output_drive_enable      = 1'b1;
    src_pol  = 1'b0;
    src_edge = 1'b0;
    src_dat  = PATTERN;
    repeat (4) @(posedge clk_i);
    chk("oe_n in reset", 32'hffff_ffff, oe_n);
    chk("hiz in reset", 32'h0000_ffff, {16'h0, hiz});
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 8; i++)
      rd_chk("reset value", reg_ofs[i], 32'h0);
    wb_xfer(1'b1, 12'h100, 32'hffff_ffff, 4'hf);
    rd_chk("unmapped", 12'h100, 32'h0);
    for (i = 2; i < 6; i++)
      wb_xfer(1'b1, reg_ofs[i], {4{4'h1 + i[3:0], 4'h9 - i[3:0]}}, 4'hf);
    for (i = 2; i < 6; i++)
      rd_chk("rate", reg_ofs[i], {4{4'h1 + i[3:0], 4'h9 - i[3:0]}});
    for (i = 2; i < 6; i++)
      wb_xfer(1'b1, reg_ofs[i], 32'h0, 4'hf);
    wb_xfer(1'b1, OFS_ICR0, 32'hffff_ffff, 4'b0100);
    rd_chk("byte lane", OFS_ICR0, 32'h00ff_0000);
    wb_xfer(1'b1, OFS_ICR0, 32'h0, 4'hf);
    wb_xfer(1'b1, OFS_MODE, 32'hc0, 4'hf);
    rd_chk("mode", OFS_MODE, 32'hc0);
    wb_xfer(1'b1, OFS_MODE, 32'h0, 4'hf);
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      src_pol  <= pc_pol[i];
      src_edge <= pc_edge[i];
      wb_xfer(1'b1, OFS_CTRL, pc_ctrl[i], 4'hf);
      wait_frame();
      repeat (805) @(posedge clk_i);
      wb_xfer(1'b0, OFS_STAT, 32'h0, 4'hf);
      chk("frame position", pc_exp[i], rdat & 32'h7ff);
    end
    $display("test frame boundary done");
    wb_xfer(1'b1, OFS_CHZ, 32'h8, 4'hf);
    wb_xfer(1'b1, OFS_HIZHI, 32'h1, 4'hf);
    wait_frame();
    {hz_cnt, hz_other, oe_bad} = '0;
    hz_first = -1;
    for (k = 0; k < 10240; k++)
    begin
      @(posedge clk_i);
      if (hiz[0] === 1'b1 && hz_first < 0)
        hz_first = k;
      if (hiz[0] === 1'b1)
        hz_cnt++;
      if (hiz[15:1] !== 15'h0)
        hz_other++;
      if (oe_n !== {14'h0, 2'b01, hiz})
        oe_bad++;
    end
    chk("slot length", 32'h1, hz_cnt >= 318 && hz_cnt <= 322);
    chk("slot start", 32'h1, hz_first >= 956 && hz_first <= 972);
    chk("driven streams", 32'h0, hz_other);
    chk("enables", 32'h0, oe_bad);
    output_drive_enable <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("oe_n drive off", 32'hffff_ffff, oe_n);
    chk("hiz drive off", 32'h0000_ffff, {16'h0, hiz});
    output_drive_enable <= 1'b1;
    wb_xfer(1'b1, OFS_CHZ, 32'h0, 4'hf);
    wb_xfer(1'b1, OFS_HIZHI, 32'h0, 4'hf);
    $display("test buffer control done");
    repeat (1000) @(posedge clk_i);
    chk("output data", PATTERN, out_w);
    wb_xfer(1'b1, OFS_MODE, 32'h40, 4'hf);
    src_dat <= ~PATTERN;
    repeat (1000) @(posedge clk_i);
    chk("bidir lower", {~PATTERN[31:16], PATTERN[15:0]}, out_w);
    wb_xfer(1'b1, OFS_MODE, 32'hc0, 4'hf);
    src_dat <= PATTERN;
    repeat (1000) @(posedge clk_i);
    chk("bidir upper", {~PATTERN[31:16], PATTERN[15:0]}, out_w);
    $display("test data path done");
    stop_test();
  end
endmodule : tdm_stream_port_timing_bench
